// *** hw/fsc_pkg.sv ***
package fsc_pkg;
  // Flash pin widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // APB register map of the controller
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;

  // Operation codes written to CTRL[2:0]
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_POLL = 3'h3;
  localparam logic [2:0] OP_RST = 3'h4;

  // STAT bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_NEEDRST = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_ERASESEL = 5;
  localparam int ST_TMOSEEN = 6;

  // Status bit positions within the low data byte
  localparam int INV_POLL_POS = 7;
  localparam int TOGGLE_POS = 6;
  localparam int TIMEOUT_POS = 5;
  localparam int ERASE_TMR_POS = 3;
  localparam int ERASE_TOG_POS = 2;

  // Command word that returns the device to array reads
  localparam logic [DATA_W-1:0] RESET_CMD = 16'h00f0;

  // Timing
  localparam int CLK_NS = 10;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 50;
  localparam int T_GAP_NS = 20;
  localparam int SYNC_CYC = 2;
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC = 4'(ACC_CYC + SYNC_CYC + 1);
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] GAP_CYC = 4'((T_GAP_NS + CLK_NS - 1) / CLK_NS);

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [2:0] {
    FS_IDLE,
    FS_RD,
    FS_RD_GAP,
    FS_WR,
    FS_WR_GAP
  } fsc_st_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe_n;
  } fsc_pins_t;

  typedef struct packed {
    fsc_st_t st;
    logic [3:0] cnt;
    logic [2:0] op;
    logic [1:0] step;
    logic [2:0] poll_rds;
    logic [DATA_W-1:0] first;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic busy;
    logic done;
    logic fail;
    logic need_rst;
    logic refused;
    logic erase_sel;
    logic tmo_seen;
    fsc_pins_t pins;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [31:0] prdata;
    logic pslverr;
  } fsc_state_t;
endpackage

// *** hw/fsc_poll_ctrl.sv ***
`timescale 1ns/100ps
module fsc_poll_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output fsc_pkg::fsc_pins_t flash_o,
  input wire logic [fsc_pkg::DATA_W-1:0] dq_i
);
  fsc_pkg::fsc_state_t s_reg;
  fsc_pkg::fsc_state_t s_next;
  logic wr_acc;
  logic rd_setup;
  logic [fsc_pkg::DATA_W-1:0] smp;
  logic tog_eq;
  logic [31:0] stat_word;

  // Zero wait states: every register answers in its access cycle
  assign pready = 1'b1;
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.pslverr;
  assign flash_o = s_reg.pins;
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign smp = s_reg.dq_s2;
  assign tog_eq = smp[fsc_pkg::TOGGLE_POS] == s_reg.first[fsc_pkg::TOGGLE_POS];

  // Assembled live; a read captures it in the setup cycle
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[fsc_pkg::ST_BUSY] = s_reg.busy;
    stat_word[fsc_pkg::ST_DONE] = s_reg.done;
    stat_word[fsc_pkg::ST_FAIL] = s_reg.fail;
    stat_word[fsc_pkg::ST_NEEDRST] = s_reg.need_rst;
    stat_word[fsc_pkg::ST_REFUSED] = s_reg.refused;
    stat_word[fsc_pkg::ST_ERASESEL] = s_reg.erase_sel;
    stat_word[fsc_pkg::ST_TMOSEEN] = s_reg.tmo_seen;
  end

  always_comb begin
    s_next = s_reg;
    // Data lines pass two flops; only the second one is ever read
    s_next.dq_s1 = dq_i;
    s_next.dq_s2 = s_reg.dq_s1;
    // Read data is captured in the setup cycle so prdata is a flop
    if (rd_setup) begin
      s_next.pslverr = 1'b0;
      unique case (paddr)
        fsc_pkg::OFF_CTRL: s_next.prdata = {29'h0, s_reg.op};
        fsc_pkg::OFF_ADDR: s_next.prdata = {13'h0, s_reg.addr_reg};
        fsc_pkg::OFF_WDATA: s_next.prdata = {16'h0, s_reg.wdata_reg};
        fsc_pkg::OFF_STAT: s_next.prdata = stat_word;
        fsc_pkg::OFF_RDATA: s_next.prdata = {16'h0, s_reg.rdata_reg};
        default: begin
          s_next.prdata = 32'h0000_0000;
          s_next.pslverr = 1'b1;
        end
      endcase
    end
    // Register writes while busy are dropped and flagged
    if (wr_acc) begin
      if (s_reg.busy) begin
        s_next.refused = 1'b1;
      end else if (paddr == fsc_pkg::OFF_ADDR) begin
        s_next.addr_reg = pwdata[fsc_pkg::ADDR_W-1:0];
      end else if (paddr == fsc_pkg::OFF_WDATA) begin
        s_next.wdata_reg = pwdata[fsc_pkg::DATA_W-1:0];
      end else if (paddr == fsc_pkg::OFF_CTRL) begin
        s_next.op = pwdata[2:0];
        s_next.refused = 1'b0;
        s_next.step = 2'h0;
        s_next.poll_rds = 3'h0;
        s_next.cnt = 4'h0;
        if (pwdata[2:0] == fsc_pkg::OP_READ && s_reg.need_rst) begin
          s_next.refused = 1'b1;
        end else if (pwdata[2:0] == fsc_pkg::OP_READ ||
                     pwdata[2:0] == fsc_pkg::OP_POLL) begin
          s_next.busy = 1'b1;
          s_next.done = 1'b0;
          s_next.st = fsc_pkg::FS_RD;
          s_next.pins.ce_n = 1'b0;
          s_next.pins.oe_n = 1'b0;
          s_next.pins.addr = s_reg.addr_reg;
          if (pwdata[2:0] == fsc_pkg::OP_POLL) begin
            s_next.fail = 1'b0;
            s_next.tmo_seen = 1'b0;
            s_next.erase_sel = 1'b0;
          end
        end else if (pwdata[2:0] == fsc_pkg::OP_WRITE ||
                     pwdata[2:0] == fsc_pkg::OP_RST) begin
          s_next.busy = 1'b1;
          s_next.done = 1'b0;
          s_next.st = fsc_pkg::FS_WR;
          s_next.pins.ce_n = 1'b0;
          s_next.pins.we_n = 1'b0;
          s_next.pins.dq_oe_n = 1'b0;
          s_next.pins.addr = s_reg.addr_reg;
          s_next.pins.dq_o = (pwdata[2:0] == fsc_pkg::OP_RST) ?
                             fsc_pkg::RESET_CMD : s_reg.wdata_reg;
        end else begin
          s_next.refused = 1'b1;
        end
      end
    end
    unique case (s_reg.st)
      fsc_pkg::FS_IDLE: begin
      end
      fsc_pkg::FS_RD: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == fsc_pkg::RD_CYC - 4'h1) begin
          // Ending the access is what advances the device toggle
          s_next.pins.ce_n = 1'b1;
          s_next.pins.oe_n = 1'b1;
          s_next.cnt = 4'h0;
          s_next.st = fsc_pkg::FS_RD_GAP;
          s_next.rdata_reg = smp;
          if (s_reg.poll_rds != 3'h7) begin
            s_next.poll_rds = s_reg.poll_rds + 3'h1;
          end
          if (s_reg.op == fsc_pkg::OP_POLL) begin
            unique case (s_reg.step)
              2'h0, 2'h2: begin
                s_next.first = smp;
                s_next.step = s_reg.step + 2'h1;
              end
              2'h1: begin
                s_next.erase_sel = smp[fsc_pkg::ERASE_TOG_POS] !=
                                   s_reg.first[fsc_pkg::ERASE_TOG_POS];
                if (tog_eq) begin
                  s_next.step = 2'h0;
                  s_next.op = fsc_pkg::OP_NONE;
                end else if (smp[fsc_pkg::TIMEOUT_POS]) begin
                  s_next.tmo_seen = 1'b1;
                  s_next.step = 2'h2;
                end else begin
                  // Nothing of the old pair is reused on the next pass
                  s_next.step = 2'h0;
                end
              end
              2'h3: begin
                s_next.step = 2'h0;
                s_next.op = fsc_pkg::OP_NONE;
                if (!tog_eq) begin
                  s_next.fail = 1'b1;
                  s_next.need_rst = 1'b1;
                end
              end
            endcase
          end else begin
            s_next.op = fsc_pkg::OP_NONE;
          end
        end
      end
      fsc_pkg::FS_RD_GAP: begin
        // The gap lets the device count each read as its own access
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == fsc_pkg::GAP_CYC - 4'h1) begin
          s_next.cnt = 4'h0;
          if (s_reg.op == fsc_pkg::OP_POLL) begin
            s_next.st = fsc_pkg::FS_RD;
            s_next.pins.ce_n = 1'b0;
            s_next.pins.oe_n = 1'b0;
          end else begin
            s_next.st = fsc_pkg::FS_IDLE;
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
          end
        end
      end
      fsc_pkg::FS_WR: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == fsc_pkg::WP_CYC - 4'h1) begin
          // Data stays driven one gap cycle past the strobe for hold
          s_next.pins.we_n = 1'b1;
          s_next.pins.ce_n = 1'b1;
          s_next.cnt = 4'h0;
          s_next.st = fsc_pkg::FS_WR_GAP;
        end
      end
      fsc_pkg::FS_WR_GAP: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        // Lines are released before the device may drive them again
        s_next.pins.dq_oe_n = 1'b1;
        if (s_reg.cnt == fsc_pkg::GAP_CYC - 4'h1) begin
          s_next.cnt = 4'h0;
          s_next.st = fsc_pkg::FS_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          if (s_reg.op == fsc_pkg::OP_RST) begin
            s_next.need_rst = 1'b0;
            s_next.fail = 1'b0;
          end
          s_next.op = fsc_pkg::OP_NONE;
        end
      end
      default: begin
        s_next.st = fsc_pkg::FS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= fsc_pkg::FS_IDLE;
      s_reg.addr_reg <= fsc_pkg::ADDR_RST;
      s_reg.wdata_reg <= fsc_pkg::DATA_RST;
      s_reg.rdata_reg <= fsc_pkg::DATA_RST;
      s_reg.pins.ce_n <= 1'b1;
      s_reg.pins.oe_n <= 1'b1;
      s_reg.pins.we_n <= 1'b1;
      s_reg.pins.dq_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Checks on the host side of the polling procedure

  no_array_rd_a: assert property (
    !s_reg.pins.oe_n |-> !(s_reg.need_rst && s_reg.op == fsc_pkg::OP_READ))
    else $error("array read issued while reset command pending");

  tmo_recheck_a: assert property (
    (s_reg.step == 2'h2) |-> s_reg.tmo_seen && s_reg.op == fsc_pkg::OP_POLL)
    else $error("recheck pair started without timeout flag");

  double_read_a: assert property (
    $fell(s_reg.op == fsc_pkg::OP_POLL) && s_reg.busy
      |-> s_reg.poll_rds >= 3'h2)
    else $error("poll finished on fewer than two reads");

  fail_after_four_a: assert property (
    $rose(s_reg.fail) |-> $past(s_reg.step) == 2'h3 && s_reg.need_rst
      && s_reg.poll_rds >= 3'h4)
    else $error("failure declared without second read pair");

  restart_pair_a: assert property (
    (s_reg.step == 2'h1 ##1 s_reg.step == 2'h0 && s_reg.busy
      && s_reg.op == fsc_pkg::OP_POLL)
      |-> s_reg.st == fsc_pkg::FS_RD_GAP ##[1:3] !s_reg.pins.oe_n)
    else $error("poll restart did not begin a new read");

  poll_addr_a: assert property (
    !s_reg.pins.ce_n && s_reg.op == fsc_pkg::OP_POLL
      |-> s_reg.pins.addr == s_reg.addr_reg && s_reg.pins.we_n)
    else $error("status read away from the selected address");

  read_release_a: assert property (
    $rose(s_reg.pins.oe_n) |-> s_reg.pins.ce_n
      && $past(s_reg.cnt) == fsc_pkg::RD_CYC - 4'h1)
    else $error("read access not ended by releasing both strobes");

  refused_read_a: assert property (
    wr_acc && paddr == fsc_pkg::OFF_CTRL && !s_reg.busy && s_reg.need_rst
      && pwdata[2:0] == fsc_pkg::OP_READ
      |=> s_reg.refused && !s_reg.busy)
    else $error("array read accepted while reset command pending");

  rst_clears_a: assert property (
    $fell(s_reg.need_rst) |-> s_reg.done && !s_reg.fail
      && $past(s_reg.op) == fsc_pkg::OP_RST)
    else $error("reset pending cleared without a reset command");

  poll_ok_c: cover property (
    $rose(s_reg.done) && s_reg.poll_rds == 3'h2 && !s_reg.fail);
  poll_fail_c: cover property ($rose(s_reg.fail));
  reset_cmd_c: cover property ($fell(s_reg.need_rst));
  restart_c: cover property (s_reg.step == 2'h1 ##1
    s_reg.step == 2'h0 && s_reg.op == fsc_pkg::OP_POLL);
  refused_c: cover property ($rose(s_reg.refused));
endmodule

// *** test/fsc_flash_model.sv ***
`timescale 1ns/100ps
module fsc_flash_model #(
  parameter int PROG_RDS = 3,
  parameter int ERASE_RDS = 5
) (
  // Pins from the controller
  input fsc_pkg::fsc_pins_t pins,
  // Device side of the data lines
  output logic [15:0] dq
);
  logic [15:0] mem [256];
  logic [15:0] q;
  logic [15:0] last = 16'h0000;
  logic [15:0] last_w = 16'h0000;
  logic [18:0] op_a = 19'h00000;
  logic tog = 1'b0;
  logic etog = 1'b0;
  logic tmo = 1'b0;
  logic ers = 1'b0;
  int busy = 0;
  wire rd = !pins.ce_n && !pins.oe_n;
  wire in_sec = pins.addr[18:11] == op_a[18:11];

  initial foreach (mem[i]) mem[i] = 16'hffff;

  always_comb begin
    q = mem[pins.addr[7:0]];
    if (busy > 0 || tmo) begin
      q = 16'h0000;
      q[7] = ers ? 1'b0 : ~last_w[7];
      q[6] = tog;
      q[5] = tmo;
      q[3] = ers;
      q[2] = ers && in_sec ? etog : 1'b0;
    end
  end
  // Released lines show the inverse of the last word, so stale data fails
  assign dq = rd ? q : ~last;

  // A read counts when its strobes are withdrawn
  always @(negedge rd) begin
    last = q;
    if (busy > 0 || tmo) begin
      tog = ~tog;
      if (ers && in_sec)
        etog = ~etog;
      if (busy == 1) begin
        if (ers) begin
          if (!op_a[18])
            foreach (mem[i]) mem[i] = 16'hffff;
        end else if (!op_a[18])
          mem[op_a[7:0]] &= last_w;
        ers = 1'b0;
      end
      if (busy > 0)
        busy--;
    end
  end

  always @(posedge pins.we_n) begin
    if (pins.dq_oe_n == 1'b0) begin
      if (pins.dq_o == fsc_pkg::RESET_CMD) begin
        busy = 0;
        tmo = 1'b0;
        ers = 1'b0;
      end else if (busy == 0 && !tmo) begin
        op_a = pins.addr;
        last_w = pins.dq_o;
        if (pins.dq_o == 16'h0030) begin
          ers = 1'b1;
          busy = ERASE_RDS;
        end else if ((pins.dq_o & ~mem[pins.addr[7:0]]) != 16'h0000)
          tmo = 1'b1;
        else
          busy = PROG_RDS;
      end
    end
  end
endmodule

// *** test/fsc_poll_ctrl_tb.sv ***
`timescale 1ns/100ps
module fsc_poll_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, stat, seed;
  logic [15:0] dq_i, dq_dev, d;
  logic [18:0] a;
  fsc_pkg::fsc_pins_t pins;
  logic [15:0] ref_mem [256];
  int progd [$];
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  fsc_poll_ctrl u_fsc_poll_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_o(pins), .dq_i(dq_i));
  fsc_flash_model u_fsc_flash_model (.pins(pins), .dq(dq_dev));
  assign dq_i = pins.dq_oe_n ? dq_dev : pins.dq_o;

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input logic [2:0] c, input logic [18:0] ad,
                    input logic [15:0] wd);
    apb(1'b1, fsc_pkg::OFF_ADDR, {13'h0000, ad});
    apb(1'b1, fsc_pkg::OFF_WDATA, {16'h0000, wd});
    apb(1'b1, fsc_pkg::OFF_CTRL, {29'h00000000, c});
    do apb(1'b0, fsc_pkg::OFF_STAT, 32'h00000000);
    while (q[fsc_pkg::ST_BUSY] !== 1'b0);
    stat = q;
  endtask

  task automatic rd_word(input logic [18:0] ad);
    op(fsc_pkg::OP_READ, ad, 16'h0000);
    apb(1'b0, fsc_pkg::OFF_RDATA, 32'h00000000);
  endtask

  task automatic rd_chk(input logic [18:0] ad, input logic [15:0] want);
    rd_word(ad);
    chk(q, {16'h0000, want});
  endtask

  task automatic prog(input logic [18:0] ad, input logic [15:0] wd);
    op(fsc_pkg::OP_WRITE, ad, wd);
    rd_word(ad);
    chk({31'h0, q[fsc_pkg::INV_POLL_POS]}, {31'h0, ~wd[7]});
    op(fsc_pkg::OP_POLL, ad, 16'h0000);
    chk(stat & 32'h0000000f, 32'h00000002);
    if (ad[18] == 1'b0)
      ref_mem[ad[7:0]] &= wd;
    rd_chk(ad, ref_mem[ad[7:0]]);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    seed = 32'hc5ef;
    foreach (ref_mem[i]) ref_mem[i] = 16'hffff;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fsc_pkg::OFF_STAT, 32'h00000000);
    chk(q, 32'h00000000);
    apb(1'b0, 8'h14, 32'h00000000);
    chk({31'h00000000, err}, 32'h00000001);
    $display("test reset_and_map ended");
    for (int i = 0; i < 4; i++) begin
      repeat (16) seed = lfsr(seed);
      a = {11'h000, seed[7:0]};
      d = seed[23:8] & ref_mem[a[7:0]] & 16'hfffe;
      progd.push_back(int'(a));
      prog(a, d);
    end
    $display("test program ended");
    // Protected block: toggles, then data stays as it was
    prog(19'h40009, 16'h0000);
    $display("test protected ended");
    op(fsc_pkg::OP_WRITE, 19'h00000, 16'h0030);
    rd_word(19'h00000);
    d = q[15:0];
    rd_word(19'h00000);
    stat = {28'h0, q[7], q[3], q[2] ^ d[2], q[6] ^ d[6]};
    chk(stat, 32'h00000007);
    op(fsc_pkg::OP_POLL, 19'h00000, 16'h0000);
    chk(stat & 32'h0000000f, 32'h00000002);
    foreach (progd[i]) rd_chk(19'(progd[i]), 16'hffff);
    foreach (ref_mem[i]) ref_mem[i] = 16'hffff;
    $display("test erase ended");
    prog(19'h00005, 16'h1234);
    // Erase aimed at a protected block only: toggles, then nothing changes
    op(fsc_pkg::OP_WRITE, 19'h40000, 16'h0030);
    op(fsc_pkg::OP_POLL, 19'h40000, 16'h0000);
    chk(stat & 32'h0000000f, 32'h00000002);
    rd_chk(19'h00005, 16'h1234);
    op(fsc_pkg::OP_WRITE, 19'h00005, 16'hffff);
    op(fsc_pkg::OP_POLL, 19'h00005, 16'h0000);
    chk(stat & 32'h0000000f, 32'h0000000e);
    op(fsc_pkg::OP_READ, 19'h00005, 16'h0000);
    chk({31'h0, stat[fsc_pkg::ST_REFUSED]}, 32'h00000001);
    op(fsc_pkg::OP_RST, 19'h00005, 16'h0000);
    rd_chk(19'h00005, 16'h1234);
    $display("test timeout ended");
    test_done();
  end
endmodule
